// ==== inc/scrp_pkg.sv ====
`default_nettype none
package scrp_pkg;
    localparam int NREG = 6;
    localparam int CNT_W = 25;
    // register offsets
    localparam logic [7:0] OFF_FAST = 8'h00;
    localparam logic [7:0] OFF_SIDE = 8'h01;
    localparam logic [7:0] OFF_TERM = 8'h10;
    localparam logic [7:0] OFF_PULSE = 8'h11;
    localparam logic [7:0] OFF_BOOST = 8'h13;
    localparam logic [7:0] OFF_DRIVE = 8'h20;
    // reset values
    localparam logic [7:0] RST_FAST = 8'h40;
    localparam logic [7:0] RST_SIDE = 8'h40;
    localparam logic [7:0] RST_TERM = 8'h01;
    localparam logic [7:0] RST_PULSE = 8'h00;
    localparam logic [7:0] RST_BOOST = 8'h00;
    localparam logic [7:0] RST_DRIVE = 8'h03;
    localparam logic [7:0] REG_OFF [NREG] = '{OFF_FAST, OFF_SIDE, OFF_TERM,
        OFF_PULSE, OFF_BOOST, OFF_DRIVE};
    localparam logic [7:0] REG_RST [NREG] = '{RST_FAST, RST_SIDE, RST_TERM,
        RST_PULSE, RST_BOOST, RST_DRIVE};
    // register indices in the bank
    localparam int IX_FAST = 0;
    localparam int IX_SIDE = 1;
    localparam int IX_TERM = 2;
    localparam int IX_PULSE = 3;
    localparam int IX_BOOST = 4;
    localparam int IX_DRIVE = 5;
    // field positions
    localparam int BIT_EN = 6;
    localparam int BIT_SEL = 0;
    localparam int BIT_TERM_ON = 0;
    localparam int PE_LSB = 2;
    localparam int BIT_OUT_TERM = 1;
    localparam int BIT_OCL = 0;
    // fixed upper slave address bits
    localparam logic [5:0] ADDR_HI = 6'h24;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_MS = 100;
    localparam int PULSE_CYC = PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int UPD_NS = 20000;
    localparam int UPD_CYC = UPD_NS / CLK_PERIOD_NS;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_DACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK = 4'h8
    } scrp_state_type;
endpackage
`default_nettype wire

// ==== core/scrp_top.sv ====
// Operation
// - reset pin low restores every register to its default
// - reset selects source A and starts that register's delay window
// - answer address 100100 plus the strapped address-select bit
// - pointer byte follows address, msb first, and is acknowledged
// - one data byte is stored into the pointed register and acked
// - device shifts out the pointed register msb first
// - pointer survives a repeated start for re-reading
// - an applied write starts its delay window at the last data bit fall
// - writes accepted during window, hardware holds until expiry
// - window not restarted by writes; last value wins at expiry
// - write after window updates hardware at once, opens new window
// - fast path enable bit 6 of 0x00: standby or on
// - fast source select bit 0 of 0x00: source A or B
// - side path enable bit 6 of 0x01: open or closed
// - side source select bit 0 of 0x01: source A or B
// - all registers readable and writable over the two-wire port
// - input termination bit off disconnects all input terminations
// - pulse bit drops that channel's termination 100 ms on switch
// - boost bit selects 6 dB or 12 dB per input channel
// - two-bit output boost selects 0, 2, 4 or 6 dB
`timescale 1ns/10ps
`default_nettype none
module scrp_top #(
    parameter int unsigned PULSE_CYC = scrp_pkg::PULSE_CYC,
    parameter int unsigned UPD_CYC = scrp_pkg::UPD_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reset_n,
    input wire logic addr_sel,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic fast_path_enable,
    output logic fast_source_select,
    output logic side_path_enable,
    output logic side_source_select,
    output logic [3:0] term_a_on,
    output logic [3:0] term_b_on,
    output logic [3:0] boost_a_high,
    output logic [3:0] boost_b_high,
    output logic [1:0] output_boost_level,
    output logic output_term_on,
    output logic output_current_level
);
    localparam int W = scrp_pkg::CNT_W;

    // pin synchronisers; the third scl/sda stage feeds edge detection
    logic rstn_s1_reg, rstn_s2_reg, adr_s1_reg, adr_s2_reg;
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rstn_s1_reg <= 1'b1;
            rstn_s2_reg <= 1'b1;
            adr_s1_reg <= 1'b0;
            adr_s2_reg <= 1'b0;
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end else begin
            rstn_s1_reg <= reset_n;
            rstn_s2_reg <= rstn_s1_reg;
            adr_s1_reg <= addr_sel;
            adr_s2_reg <= adr_s1_reg;
            scl_s1_reg <= scl_i;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    // bus conditions; start and stop only while scl stays high
    logic rst_all, scl_rise, scl_fall, bus_start, bus_stop;
    assign rst_all = srst | ~rstn_s2_reg;
    assign scl_rise = scl_s2_reg & ~scl_s3_reg;
    assign scl_fall = ~scl_s2_reg & scl_s3_reg;
    assign bus_start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
    assign bus_stop = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

    scrp_pkg::scrp_state_type st_reg, st_next;
    logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, rd_data;
    logic [3:0] bcnt_reg, bcnt_next;
    logic rw_reg, rw_next, oe_reg, oe_next, wr_stb;
    logic [7:0] cfg_reg [scrp_pkg::NREG];
    logic [7:0] cfg_next [scrp_pkg::NREG];
    logic [7:0] app_reg [scrp_pkg::NREG];
    logic [7:0] app_next [scrp_pkg::NREG];
    logic [W-1:0] cnt_reg [scrp_pkg::NREG];
    logic [W-1:0] cnt_next [scrp_pkg::NREG];
    logic [scrp_pkg::NREG-1:0] hit;
    logic [W-1:0] pulse_reg, pulse_next;
    logic [7:0] term_reg, term_next;

    // read mux; unmapped pointers read as zero
    always_comb begin
        rd_data = 8'h00;
        for (int i = 0; i < scrp_pkg::NREG; i++) begin
            if (ptr_reg == scrp_pkg::REG_OFF[i]) begin
                rd_data = cfg_reg[i];
            end
        end
    end

    // serial protocol engine
    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        bcnt_next = bcnt_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        wr_stb = 1'b0;
        if (bus_start) begin
            // pointer left alone so a restart can re-read it
            st_next = scrp_pkg::ST_ADDR;
            bcnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            st_next = scrp_pkg::ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                scrp_pkg::ST_ADDR, scrp_pkg::ST_PTR,
                scrp_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        sh_next = {sh_reg[6:0], sda_s2_reg};
                        bcnt_next = bcnt_reg + 4'h1;
                    end else if (scl_fall && bcnt_reg == 4'h8) begin
                        bcnt_next = 4'h0;
                        case (st_reg)
                            scrp_pkg::ST_ADDR: begin
                                if (sh_reg[7:1] ==
                                    {scrp_pkg::ADDR_HI, adr_s2_reg}) begin
                                    oe_next = 1'b1;
                                    rw_next = sh_reg[0];
                                    st_next = scrp_pkg::ST_AACK;
                                end else begin
                                    // stay off the bus until next start
                                    st_next = scrp_pkg::ST_IDLE;
                                end
                            end
                            scrp_pkg::ST_PTR: begin
                                ptr_next = sh_reg;
                                oe_next = 1'b1;
                                st_next = scrp_pkg::ST_PACK;
                            end
                            default: begin
                                wr_stb = 1'b1;
                                oe_next = 1'b1;
                                st_next = scrp_pkg::ST_DACK;
                            end
                        endcase
                    end
                end
                scrp_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            sh_next = rd_data;
                            oe_next = ~rd_data[7];
                            st_next = scrp_pkg::ST_RDATA;
                        end else begin
                            oe_next = 1'b0;
                            st_next = scrp_pkg::ST_PTR;
                        end
                    end
                end
                scrp_pkg::ST_PACK, scrp_pkg::ST_DACK: begin
                    // extra bytes rewrite the same pointed register
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        st_next = scrp_pkg::ST_WDATA;
                    end
                end
                scrp_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        bcnt_next = bcnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bcnt_reg == 4'h8) begin
                            bcnt_next = 4'h0;
                            oe_next = 1'b0;
                            st_next = scrp_pkg::ST_RACK;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                        end
                    end
                end
                scrp_pkg::ST_RACK: begin
                    // one byte per read: the line is left free after the
                    // master's acknowledge, so its stop or restart can follow
                    if (scl_fall) begin
                        st_next = scrp_pkg::ST_IDLE;
                    end
                end
                default: st_next = scrp_pkg::ST_IDLE;
            endcase
        end
        if (rst_all) begin
            st_next = scrp_pkg::ST_IDLE;
            sh_next = 8'h00;
            bcnt_next = 4'h0;
            ptr_next = 8'h00;
            rw_next = 1'b0;
            oe_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_reg <= st_next;
        sh_reg <= sh_next;
        bcnt_reg <= bcnt_next;
        ptr_reg <= ptr_next;
        rw_reg <= rw_next;
        oe_reg <= oe_next;
    end

    // written copy, applied copy and delay window per register;
    // the window is not restarted so a write storm cannot stall it
    always_comb begin
        for (int i = 0; i < scrp_pkg::NREG; i++) begin
            hit[i] = wr_stb && (ptr_reg == scrp_pkg::REG_OFF[i]);
            cfg_next[i] = hit[i] ? sh_reg : cfg_reg[i];
            app_next[i] = app_reg[i];
            cnt_next[i] = cnt_reg[i];
            if (cnt_reg[i] == '0) begin
                if (hit[i]) begin
                    app_next[i] = sh_reg;
                    cnt_next[i] = W'(UPD_CYC);
                end
            end else begin
                cnt_next[i] = cnt_reg[i] - W'(1);
                if (cnt_reg[i] == W'(1)) begin
                    app_next[i] = cfg_next[i];
                end
            end
            if (rst_all) begin
                cfg_next[i] = scrp_pkg::REG_RST[i];
                app_next[i] = scrp_pkg::REG_RST[i];
                cnt_next[i] = (i == scrp_pkg::IX_FAST) ? W'(UPD_CYC) : '0;
            end
        end
    end

    // termination pulse on a fast source change, plus channel mapping;
    // pulse bits 4..7 map to B3..B0, stored here as B0..B3
    always_comb begin
        pulse_next = (pulse_reg != '0) ? pulse_reg - W'(1) : '0;
        if (app_next[scrp_pkg::IX_FAST][scrp_pkg::BIT_SEL] !=
            app_reg[scrp_pkg::IX_FAST][scrp_pkg::BIT_SEL]) begin
            pulse_next = W'(PULSE_CYC);
        end
        for (int k = 0; k < 8; k++) begin
            term_next[k] = app_reg[scrp_pkg::IX_TERM][scrp_pkg::BIT_TERM_ON]
                & ~((pulse_reg != '0) &
                app_reg[scrp_pkg::IX_PULSE][(k < 4) ? k : 11 - k]);
        end
        if (rst_all) begin
            pulse_next = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        cfg_reg <= cfg_next;
        app_reg <= app_next;
        cnt_reg <= cnt_next;
        pulse_reg <= pulse_next;
        term_reg <= term_next;
    end

    // outputs other than sda_o, which is tied low, are bits of the applied copy or of flops above
    assign sda_o = 1'b0;
    assign sda_oe = oe_reg;
    assign fast_path_enable = app_reg[0][scrp_pkg::BIT_EN];
    assign fast_source_select = app_reg[0][scrp_pkg::BIT_SEL];
    assign side_path_enable = app_reg[1][scrp_pkg::BIT_EN];
    assign side_source_select = app_reg[1][scrp_pkg::BIT_SEL];
    assign term_a_on = term_reg[3:0];
    assign term_b_on = term_reg[7:4];
    assign boost_a_high = app_reg[scrp_pkg::IX_BOOST][3:0];
    assign boost_b_high = {app_reg[scrp_pkg::IX_BOOST][4],
        app_reg[scrp_pkg::IX_BOOST][5], app_reg[scrp_pkg::IX_BOOST][6],
        app_reg[scrp_pkg::IX_BOOST][7]};
    assign output_boost_level =
        app_reg[scrp_pkg::IX_DRIVE][scrp_pkg::PE_LSB +: 2];
    assign output_term_on = app_reg[scrp_pkg::IX_DRIVE][scrp_pkg::BIT_OUT_TERM];
    assign output_current_level = app_reg[scrp_pkg::IX_DRIVE][scrp_pkg::BIT_OCL];

    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_addr_done;
        st_reg == scrp_pkg::ST_ADDR && !bus_start && !bus_stop && !rst_all
            && scl_fall && bcnt_reg == 4'h8;
    endsequence
    sequence s_fast_write;
        hit[0] && !rst_all;
    endsequence
    property p_reset_default;
        rst_all |=> app_reg[0] == scrp_pkg::RST_FAST
            && cfg_reg[5] == scrp_pkg::RST_DRIVE && !sda_oe;
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("defaults not restored by reset");
    property p_reset_window;
        rst_all |=> !fast_source_select && cnt_reg[0] == W'(UPD_CYC);
    endproperty
    a_reset_window: assert property (p_reset_window)
        else $error("reset did not open source window");
    property p_addr_ack;
        s_addr_done ##0 (sh_reg[7:1] == {scrp_pkg::ADDR_HI, adr_s2_reg})
            |=> sda_oe ##1 sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acknowledged");
    property p_addr_nack;
        s_addr_done ##0 (sh_reg[7:1] != {scrp_pkg::ADDR_HI, adr_s2_reg})
            |=> !sda_oe && st_reg == scrp_pkg::ST_IDLE;
    endproperty
    a_addr_nack: assert property (p_addr_nack)
        else $error("foreign address acknowledged");
    property p_store;
        s_fast_write |=> cfg_reg[0] == $past(sh_reg) && sda_oe;
    endproperty
    a_store: assert property (p_store)
        else $error("written byte not stored");
    property p_hold;
        cnt_reg[0] > W'(1) && !rst_all |=> $stable(fast_source_select)
            && $stable(fast_path_enable);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hardware changed inside window");
    property p_no_restart;
        s_fast_write ##0 cnt_reg[0] > W'(1)
            |=> cnt_reg[0] == $past(cnt_reg[0]) - W'(1);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("write restarted the window");
    property p_immediate;
        s_fast_write ##0 cnt_reg[0] == '0
            |=> app_reg[0] == $past(sh_reg) && cnt_reg[0] == W'(UPD_CYC);
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("idle write not applied at once");
    property p_pulse;
        pulse_reg != '0 && app_reg[3][0] && !rst_all |=> !term_a_on[0];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("termination kept during pulse");
endmodule
`default_nettype wire

// ==== bench/scrp_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// two-wire bus master; its clock stands high outside frames
module scrp_master_model (
    input wire logic clk_sys,
    input wire logic sda_o,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic sda_drv;
    logic [7:0] rd_byte;
    time t_fall;
    time t_data;
    event rd_done;
    // pull-up: the line is low while either party pulls it
    assign sda = sda_drv & ~(sda_oe & ~sda_o);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // a quarter of the 64 ns bit, paced on the falling edge
    task automatic q();
        repeat (4) @(negedge clk_sys);
    endtask
    // data falls while the clock is high
    task automatic start();
        sda_drv = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    // data rises while the clock is high, then the bus is left free
    task automatic stop();
        sda_drv = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b1;
        q();
    endtask
    // data set while the clock is low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        t_fall = $time;
        q();
    endtask
    // msb first, then the line is let go for the acknowledge
    task automatic byte_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        t_data = t_fall;
        bit_io(1'b1, ack);
    endtask
    // the port lets the line go after each read byte, then the given nack bit is driven as the acknowledge
    task automatic byte_rd(input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, rd_byte[i]);
        end
        bit_io(nack, r);
        -> rd_done;
    endtask
endmodule
`default_nettype wire

// ==== bench/serial_config_register_port_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_config_register_port_test;
    localparam int UPD = 2000;
    localparam int PUL = 200;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic reset_n = 1'b1;
    logic addr_sel = 1'b0;
    logic scl, sda, sda_o, sda_oe, fpe, fss, spe, sss, otm, ocl, a;
    logic [3:0] term_a, term_b, ba, bb;
    logic [1:0] obl;
    logic [7:0] exp_q[$];
    logic [7:0] vals [6];
    int failures = 0;
    int samples_checked = 0;
    int seed = 32'h34fa;
    time t1;

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    // short windows keep the run small; expectations use the same values
    scrp_top #(.PULSE_CYC(PUL), .UPD_CYC(UPD)) scrp_top_inst (
        .clk_sys(clk_sys), .srst(srst), .reset_n(reset_n),
        .addr_sel(addr_sel), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .fast_path_enable(fpe), .fast_source_select(fss),
        .side_path_enable(spe), .side_source_select(sss),
        .term_a_on(term_a), .term_b_on(term_b), .boost_a_high(ba),
        .boost_b_high(bb), .output_boost_level(obl),
        .output_term_on(otm), .output_current_level(ocl)
    );
    scrp_master_model scrp_master_model_inst (
        .clk_sys(clk_sys), .sda_o(sda_o), .sda_oe(sda_oe),
        .scl(scl), .sda(sda)
    );

    task automatic check_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic check_byte(input string n, input logic [7:0] e,
            input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // own address with the current strap, must be acknowledged
    task automatic addr(input logic rw);
        scrp_master_model_inst.byte_wr({scrp_pkg::ADDR_HI, addr_sel, rw}, a);
        check_bit("address ack", 1'b0, a);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        scrp_master_model_inst.start();
        addr(1'b0);
        scrp_master_model_inst.byte_wr(p, a);
        check_bit("pointer ack", 1'b0, a);
        scrp_master_model_inst.byte_wr(d, a);
        check_bit("data ack", 1'b0, a);
        scrp_master_model_inst.stop();
    endtask
    // the expected byte is queued before the bus is touched
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        exp_q.push_back(e);
        scrp_master_model_inst.start();
        addr(1'b0);
        scrp_master_model_inst.byte_wr(p, a);
        check_bit("pointer ack", 1'b0, a);
        scrp_master_model_inst.start();
        addr(1'b1);
        scrp_master_model_inst.byte_rd(1'b0);
        scrp_master_model_inst.stop();
    endtask
    // read again with no pointer sent
    task automatic reread(input logic [7:0] e);
        exp_q.push_back(e);
        scrp_master_model_inst.start();
        addr(1'b1);
        scrp_master_model_inst.byte_rd(1'b0);
        scrp_master_model_inst.stop();
    endtask

    // every finished read byte is matched with the oldest note
    always @(scrp_master_model_inst.rd_done) begin
        if (exp_q.size() > 0) begin
            check_byte("read data", exp_q.pop_front(),
                scrp_master_model_inst.rd_byte);
        end
    end
    // cut a hang short
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    // main sequence; all inputs move on the falling edge
    initial begin
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < scrp_pkg::NREG; i++) begin
            rd(scrp_pkg::REG_OFF[i], scrp_pkg::REG_RST[i]);
        end
        check_bit("fast enable", 1'b1, fpe);
        check_bit("fast select", 1'b0, fss);
        check_byte("terms", 8'hff, {term_b, term_a});
        check_byte("drive", 8'h03, {4'h0, obl, otm, ocl});
        // each window is idle, so each write lands at once
        for (int i = 0; i < scrp_pkg::NREG; i++) begin
            vals[i] = 8'($random(seed));
            wr(scrp_pkg::REG_OFF[i], vals[i]);
            rd(scrp_pkg::REG_OFF[i], vals[i]);
        end
        check_bit("fast enable", vals[0][6], fpe);
        check_bit("fast select", vals[0][0], fss);
        check_bit("side enable", vals[1][6], spe);
        check_bit("side select", vals[1][0], sss);
        check_byte("boost", vals[4], {bb[0], bb[1], bb[2], bb[3], ba});
        check_byte("drive", {4'h0, vals[5][3:0]}, {4'h0, obl, otm, ocl});
        // both strap levels; the other address must be ignored
        for (int s = 0; s < 2; s++) begin
            addr_sel = s[0];
            repeat (4) @(negedge clk_sys);
            scrp_master_model_inst.start();
            scrp_master_model_inst.byte_wr({scrp_pkg::ADDR_HI, ~addr_sel, 1'b0}, a);
            scrp_master_model_inst.stop();
            check_bit("foreign address ack", 1'b1, a);
            rd(scrp_pkg::OFF_DRIVE, vals[5]);
            reread(vals[5]);
        end
        // writes inside a window: held, not restarted, last one wins
        repeat (UPD) @(negedge clk_sys);
        wr(scrp_pkg::OFF_FAST, 8'h40);
        t1 = scrp_master_model_inst.t_data;
        check_bit("fast select", 1'b0, fss);
        wr(scrp_pkg::OFF_FAST, 8'h01);
        wr(scrp_pkg::OFF_FAST, 8'h41);
        rd(scrp_pkg::OFF_FAST, 8'h41);
        check_bit("fast select", 1'b0, fss);
        repeat (int'(t1 / 4) + UPD - 16 - int'($time / 4)) @(negedge clk_sys);
        check_bit("fast select", 1'b0, fss);
        repeat (32) @(negedge clk_sys);
        check_bit("fast select", 1'b1, fss);
        check_bit("fast enable", 1'b1, fpe);
        // terminations off, then dropped briefly on a source switch
        wr(scrp_pkg::OFF_PULSE, 8'h81);
        wr(scrp_pkg::OFF_TERM, 8'h00);
        repeat (4) @(negedge clk_sys);
        check_byte("terms", 8'h00, {term_b, term_a});
        repeat (UPD) @(negedge clk_sys);
        wr(scrp_pkg::OFF_TERM, 8'h01);
        wr(scrp_pkg::OFF_FAST, 8'h40);
        check_byte("terms", 8'hee, {term_b, term_a});
        repeat (PUL) @(negedge clk_sys);
        check_byte("terms", 8'hff, {term_b, term_a});
        // reset pin mid-run restores defaults and opens the select window
        wr(scrp_pkg::OFF_DRIVE, 8'h08);
        check_byte("drive", 8'h08, {4'h0, obl, otm, ocl});
        reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check_byte("drive", 8'h03, {4'h0, obl, otm, ocl});
        wr(scrp_pkg::OFF_FAST, 8'h41);
        check_bit("fast select", 1'b0, fss);
        rd(scrp_pkg::OFF_DRIVE, 8'h03);
        repeat (UPD) @(negedge clk_sys);
        check_bit("fast select", 1'b1, fss);
        give_verdict();
    end
endmodule
`default_nettype wire
